// >>> src/aocal_pkg.sv
// Package: register map, field codes and correction constants for the analog output and calibration block
package aocal_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_SETTING  = 8'h00;
  localparam logic [7:0] OFF_OUT_VAL0 = 8'h04;
  localparam logic [7:0] OFF_OUT_VAL1 = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_CAL_CTRL = 8'h10;
  localparam logic [7:0] OFF_OUT_GN0  = 8'h14;
  localparam logic [7:0] OFF_OUT_GN1  = 8'h18;
  localparam logic [7:0] OFF_OUT_OF0  = 8'h1C;
  localparam logic [7:0] OFF_OUT_OF1  = 8'h20;
  localparam logic [7:0] OFF_OUT_CD0  = 8'h24;
  localparam logic [7:0] OFF_OUT_CD1  = 8'h28;
  localparam logic [2:0] BLK_IN_GAIN  = 3'h2;
  localparam logic [2:0] BLK_IN_OFS   = 3'h3;

  // System setting command word fields
  localparam logic [7:0] SET_RANGE_NUM = 8'h19;
  localparam logic [7:0] CH1_CODE      = 8'h01;
  localparam logic [7:0] CH2_CODE      = 8'h02;
  localparam logic [7:0] RANGE_5V      = 8'h01;
  localparam logic [7:0] RANGE_10V     = 8'h02;

  // Calibration control bits
  localparam int CTRL_SAVED_BIT  = 0;
  localparam int CTRL_REBOOT_BIT = 1;

  // Correction arithmetic
  localparam logic [13:0]        GAIN_SCALE = 14'h2710;
  localparam logic signed [7:0]  OFS_LIMIT  = 8'sh64;
  localparam logic [11:0]        CODE_MAX   = 12'hFFF;
  localparam logic [11:0]        RESET_CODE = 12'h000;
  localparam int                 DIV_STEPS  = 30;

  // Correction engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } eng_t;

  // Clamp a written zero offset into its legal window
  function automatic logic [7:0] clamp_ofs(input logic [15:0] w);
    logic signed [15:0] v;
    v = $signed(w);
    if (v > 16'sd100) begin
      clamp_ofs = OFS_LIMIT;
    end else if (v < -16'sd100) begin
      clamp_ofs = -OFS_LIMIT;
    end else begin
      clamp_ofs = w[7:0];
    end
  endfunction

endpackage

// >>> src/gain_divider.sv
// Sequential gain stage: value * (10000 + k) / 10000, truncated toward zero
`timescale 1ns/100ps
module gain_divider (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // Request
  input  wire logic               start,
  input  wire logic [11:0]        value,
  input  wire logic signed [15:0] k,
  // Result
  output logic                    done,
  output logic signed [17:0]      quotient
);
  import aocal_pkg::*;

  typedef struct packed {
    logic [29:0] mag;
    logic [13:0] rem;
    logic [4:0]  cnt;
    logic        neg;
    logic        busy;
    logic        done;
  } div_t;

  div_t s_reg, s_next;
  logic signed [16:0] factor;
  logic signed [29:0] prod;
  logic [14:0]        trial;
  logic               ge;

  // Product first, then restoring division by the scale; one quotient bit per clock
  always_comb begin
    factor = $signed({3'b000, GAIN_SCALE}) + 17'(k); // Widened unsigned: the scale's top bit is not a sign
    prod   = 30'($signed({1'b0, value}) * factor);
    trial  = {s_reg.rem, s_reg.mag[29]};
    ge     = (trial >= {1'b0, GAIN_SCALE});
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start && !s_reg.busy) begin
      s_next.mag  = prod[29] ? 30'(-prod) : prod;
      s_next.neg  = prod[29];
      s_next.rem  = '0;
      s_next.cnt  = 5'(DIV_STEPS - 1);
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      s_next.rem = ge ? 14'(trial - {1'b0, GAIN_SCALE}) : trial[13:0];
      s_next.mag = {s_reg.mag[28:0], ge};
      s_next.cnt = s_reg.cnt - 5'h01;
      if (s_reg.cnt == 5'h00) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Sign is restored after dividing the magnitude, so rounding is toward zero
  assign done     = s_reg.done;
  assign quotient = s_reg.neg ? -$signed({1'b0, s_reg.mag[16:0]}) : $signed({1'b0, s_reg.mag[16:0]});

  a_div_latency: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (start && !s_reg.busy) |-> ##31 s_reg.done) else $error("gain stage did not finish in 31 cycles");

endmodule

// >>> src/offset_saturate.sv
// Zero-offset addition followed by clamping to the 12-bit code range
`timescale 1ns/100ps
module offset_saturate (
  // Operands
  input  wire logic signed [17:0] gained,
  input  wire logic signed [7:0]  ofs,
  // Clamped code
  output logic [11:0]             code
);
  import aocal_pkg::*;

  logic signed [18:0] sum;

  // Offset goes on after the gain; the sum is pinned at both ends
  always_comb begin
    sum = 19'(gained) + 19'(ofs);
    if (sum < 19'sd0) begin
      code = RESET_CODE;
    end else if (sum > $signed({7'h00, CODE_MAX})) begin
      code = CODE_MAX;
    end else begin
      code = sum[11:0];
    end
  end

endmodule

// >>> src/analog_out_calibration.sv
// Analog output range and value control with gain and zero-offset correction of outputs and input readings
`timescale 1ns/100ps
module analog_out_calibration #(
  parameter int NCH = 8
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Raw readings from the converter
  input  wire logic                   adc_in_valid,
  input  wire logic [$clog2(NCH)-1:0] adc_in_chan,
  input  wire logic [11:0]            adc_in_raw,
  output logic                        adc_in_ready,
  // Corrected readings
  output logic                        adc_out_valid,
  output logic [$clog2(NCH)-1:0]      adc_out_chan,
  output logic [11:0]                 adc_out_data,
  // Output converter
  output logic [11:0]                 dac_code_0,
  output logic [11:0]                 dac_code_1,
  output logic [1:0]                  range_10v
);
  import aocal_pkg::*;

  localparam int CW = $clog2(NCH);

  typedef struct packed {
    logic                   hready;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic                   rd_pend;
    logic                   wr_pend;
    logic [7:0]             addr;
    logic [15:0]            setting_word;
    logic [1:0]             range_10v;
    logic [1:0][11:0]       set_val;
    logic [1:0][11:0]       dac_code;
    logic [1:0][15:0]       out_gain_st;
    logic [1:0][15:0]       out_gain;
    logic [1:0][7:0]        out_ofs_st;
    logic [1:0][7:0]        out_ofs;
    logic [NCH-1:0][15:0]   in_gain_st;
    logic [NCH-1:0][15:0]   in_gain;
    logic [NCH-1:0][7:0]    in_ofs_st;
    logic [NCH-1:0][7:0]    in_ofs;
    logic [1:0]             dac_pend;
    logic                   adc_pend;
    logic                   adc_ready;
    logic [CW-1:0]          adc_chan;
    logic [11:0]            adc_raw;
    eng_t                   eng;
    logic [1:0]             job;
    logic                   res_valid;
    logic [CW-1:0]          res_chan;
    logic [11:0]            res_data;
    logic                   restart;
  } state_t;

  state_t s_reg, s_next;

  logic               div_start;
  logic [1:0]         sel_job;
  logic [11:0]        op_val;
  logic [15:0]        op_gain;
  logic [7:0]         op_ofs;
  logic               div_done;
  logic signed [17:0] div_q;
  logic [11:0]        corr_code;
  logic [31:0]        rd_word;
  logic [2:0]         ridx;

  // Shared gain stage serves both outputs and every input channel in turn
  gain_divider u_gain (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .start    (div_start),
    .value    (op_val),
    .k        ($signed(op_gain)),
    .done     (div_done),
    .quotient (div_q)
  );

  // Offset and clamp act on the finished quotient
  offset_saturate u_ofs (
    .gained (div_q),
    .ofs    ($signed(op_ofs)),
    .code   (corr_code)
  );

  // Read data for the register held in the data phase
  always_comb begin
    ridx    = s_reg.addr[4:2];
    rd_word = 32'h0000_0000;
    case (s_reg.addr)
      OFF_SETTING:  rd_word = {16'h0000, s_reg.setting_word};
      OFF_OUT_VAL0: rd_word = {20'h00000, s_reg.set_val[0]};
      OFF_OUT_VAL1: rd_word = {20'h00000, s_reg.set_val[1]};
      OFF_STATUS:   rd_word = {26'h0000000, s_reg.adc_pend, s_reg.dac_pend, s_reg.eng == ENG_RUN, s_reg.range_10v};
      OFF_OUT_GN0:  rd_word = {{16{s_reg.out_gain_st[0][15]}}, s_reg.out_gain_st[0]};
      OFF_OUT_GN1:  rd_word = {{16{s_reg.out_gain_st[1][15]}}, s_reg.out_gain_st[1]};
      OFF_OUT_OF0:  rd_word = {{24{s_reg.out_ofs_st[0][7]}}, s_reg.out_ofs_st[0]};
      OFF_OUT_OF1:  rd_word = {{24{s_reg.out_ofs_st[1][7]}}, s_reg.out_ofs_st[1]};
      OFF_OUT_CD0:  rd_word = {20'h00000, s_reg.dac_code[0]};
      OFF_OUT_CD1:  rd_word = {20'h00000, s_reg.dac_code[1]};
      default: begin
        if (s_reg.addr[7:5] == BLK_IN_GAIN && int'(ridx) < NCH) begin
          rd_word = {{16{s_reg.in_gain_st[ridx][15]}}, s_reg.in_gain_st[ridx]};
        end else if (s_reg.addr[7:5] == BLK_IN_OFS && int'(ridx) < NCH) begin
          rd_word = {{24{s_reg.in_ofs_st[ridx][7]}}, s_reg.in_ofs_st[ridx]};
        end
      end
    endcase
  end

  // Operand selection: a new job picks by priority, a running job keeps its own
  always_comb begin
    if (s_reg.dac_pend[0]) begin
      sel_job = 2'h0;
    end else if (s_reg.dac_pend[1]) begin
      sel_job = 2'h1;
    end else begin
      sel_job = 2'h2;
    end
    div_start = (s_reg.eng == ENG_IDLE) && (s_reg.dac_pend != 2'b00 || s_reg.adc_pend);
    case (div_start ? sel_job : s_reg.job)
      2'h0: begin
        op_val  = s_reg.set_val[0];
        op_gain = s_reg.out_gain[0];
        op_ofs  = s_reg.out_ofs[0];
      end
      2'h1: begin
        op_val  = s_reg.set_val[1];
        op_gain = s_reg.out_gain[1];
        op_ofs  = s_reg.out_ofs[1];
      end
      default: begin
        op_val  = s_reg.adc_raw;
        op_gain = s_reg.in_gain[s_reg.adc_chan];
        op_ofs  = s_reg.in_ofs[s_reg.adc_chan];
      end
    endcase
  end

  // Next state: bus, configuration, restart and correction sequencing
  always_comb begin
    s_next           = s_reg;
    s_next.wr_pend   = 1'b0;
    s_next.res_valid = 1'b0;
    s_next.restart   = 1'b0;
    s_next.hresp     = 1'b0;
    // Read data phase: one wait state so a write just before is already visible
    if (s_reg.rd_pend) begin
      s_next.hrdata  = rd_word;
      s_next.rd_pend = 1'b0;
      s_next.hready  = 1'b1;
    end
    // Correction engine; clearing a pending flag comes before any new request below
    case (s_reg.eng)
      ENG_IDLE: begin
        if (div_start) begin
          s_next.eng = ENG_RUN;
          s_next.job = sel_job;
          if (sel_job != 2'h2) begin
            s_next.dac_pend[sel_job[0]] = 1'b0;
          end
        end
      end
      ENG_RUN: begin
        if (div_done) begin
          s_next.eng = ENG_IDLE;
          if (s_reg.job == 2'h2) begin
            s_next.res_valid = 1'b1;
            s_next.res_chan  = s_reg.adc_chan;
            s_next.res_data  = corr_code;
            s_next.adc_pend  = 1'b0;
          end else begin
            s_next.dac_code[s_reg.job[0]] = corr_code;
          end
        end
      end
      default: begin
        s_next.eng = ENG_IDLE;
      end
    endcase
    // Register writes in the data phase
    if (s_reg.wr_pend) begin
      case (s_reg.addr)
        OFF_SETTING: begin
          s_next.setting_word = hwdata[15:0];
          if (hwdata[23:16] == SET_RANGE_NUM && (hwdata[7:0] == RANGE_5V || hwdata[7:0] == RANGE_10V)) begin
            if (hwdata[15:8] == CH1_CODE) begin
              s_next.range_10v[0] = (hwdata[7:0] == RANGE_10V);
            end else if (hwdata[15:8] == CH2_CODE) begin
              s_next.range_10v[1] = (hwdata[7:0] == RANGE_10V);
            end
          end
        end
        OFF_OUT_VAL0: begin
          s_next.set_val[0]  = hwdata[11:0];
          s_next.dac_pend[0] = 1'b1;
        end
        OFF_OUT_VAL1: begin
          s_next.set_val[1]  = hwdata[11:0];
          s_next.dac_pend[1] = 1'b1;
        end
        OFF_CAL_CTRL: begin
          s_next.restart = hwdata[CTRL_SAVED_BIT] && hwdata[CTRL_REBOOT_BIT];
        end
        OFF_OUT_GN0: s_next.out_gain_st[0] = hwdata[15:0];
        OFF_OUT_GN1: s_next.out_gain_st[1] = hwdata[15:0];
        OFF_OUT_OF0: s_next.out_ofs_st[0]  = clamp_ofs(hwdata[15:0]);
        OFF_OUT_OF1: s_next.out_ofs_st[1]  = clamp_ofs(hwdata[15:0]);
        default: begin
          if (s_reg.addr[7:5] == BLK_IN_GAIN && int'(ridx) < NCH) begin
            s_next.in_gain_st[ridx] = hwdata[15:0];
          end else if (s_reg.addr[7:5] == BLK_IN_OFS && int'(ridx) < NCH) begin
            s_next.in_ofs_st[ridx] = clamp_ofs(hwdata[15:0]);
          end
        end
      endcase
    end
    // Self restart: stored constants become active, outputs return to their start-up state
    if (s_next.restart) begin
      s_next.out_gain  = s_reg.out_gain_st;
      s_next.out_ofs   = s_reg.out_ofs_st;
      s_next.in_gain   = s_reg.in_gain_st;
      s_next.in_ofs    = s_reg.in_ofs_st;
      s_next.range_10v = 2'b00;
      s_next.set_val   = '0;
      s_next.dac_pend  = 2'b11;
    end
    // Raw reading accepted while no reading waits
    if (adc_in_valid && s_reg.adc_ready) begin
      s_next.adc_pend = 1'b1;
      s_next.adc_chan = adc_in_chan;
      s_next.adc_raw  = adc_in_raw;
    end
    s_next.adc_ready = !s_next.adc_pend;
    // Address phase capture
    if (hsel && hready && htrans[1]) begin
      s_next.addr    = haddr[7:0];
      s_next.wr_pend = hwrite;
      s_next.rd_pend = !hwrite;
      s_next.hready  = hwrite;
    end
  end

  // State register; reset gives unity gain, zero offset and the 0-5V range
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg           <= '0;
      s_reg.hready    <= 1'b1;
      s_reg.adc_ready <= 1'b1;
      s_reg.eng       <= ENG_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign hreadyout     = s_reg.hready;
  assign hresp         = s_reg.hresp;
  assign hrdata        = s_reg.hrdata;
  assign adc_in_ready  = s_reg.adc_ready;
  assign adc_out_valid = s_reg.res_valid;
  assign adc_out_chan  = s_reg.res_chan;
  assign adc_out_data  = s_reg.res_data;
  assign dac_code_0    = s_reg.dac_code[0];
  assign dac_code_1    = s_reg.dac_code[1];
  assign range_10v     = s_reg.range_10v;

  a_range_to_10v: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.wr_pend && s_reg.addr == OFF_SETTING && hwdata[23:0] == 24'h190202)
    |=> range_10v[1] && $stable(range_10v[0])) else $error("channel two range not set to 10V");

  a_range_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_reg.restart |-> range_10v == 2'b00) else $error("range not 0-5V after restart");

  a_code_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(s_reg.eng == ENG_RUN && div_done && s_reg.job == 2'h0) |=> $stable(dac_code_0))
    else $error("output code changed without a finished correction");

  a_const_deferred: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !s_next.restart |=> $stable(s_reg.in_gain) && $stable(s_reg.in_ofs))
    else $error("input constants changed without a restart");

  a_restart_loads: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.wr_pend && s_reg.addr == OFF_CAL_CTRL && hwdata[1:0] == 2'b11)
    |=> s_reg.in_gain == $past(s_reg.in_gain_st) && s_reg.dac_pend != 2'b00)
    else $error("restart did not load stored constants");

  a_out_recompute: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.wr_pend && s_reg.addr == OFF_OUT_VAL0) |=> ##[0:70] (div_done && s_reg.job == 2'h0))
    else $error("output value not corrected in time");

  a_ofs_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $signed(s_reg.out_ofs_st[0]) <= OFS_LIMIT && $signed(s_reg.out_ofs_st[0]) >= -OFS_LIMIT)
    else $error("output zero offset outside its window");

  a_neg_clamps: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.eng == ENG_RUN && div_done && s_reg.job == 2'h2 && (19'(div_q) + 19'($signed(op_ofs))) < 19'sd0)
    |=> adc_out_valid && adc_out_data == 12'h000) else $error("negative reading not clamped to zero");

  a_bus_okay: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_reg.rd_pend |=> hreadyout && !hresp) else $error("read data phase not ended after one wait");

  a_range_indep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.wr_pend && s_reg.addr == OFF_SETTING && hwdata[15:8] == CH1_CODE)
    |=> $stable(range_10v[1])) else $error("channel two range moved by a channel one command");

  a_no_reboot: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.wr_pend && s_reg.addr == OFF_CAL_CTRL && hwdata[1:0] == 2'b01)
    |=> !s_reg.restart && $stable(s_reg.in_gain)) else $error("restart without the reboot request");

  a_result_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_reg.eng == ENG_RUN && div_done && s_reg.job == 2'h2)
    |=> adc_out_valid && adc_out_data == $past(corr_code)) else $error("corrected reading not delivered");

endmodule

// >>> test/adc_model.sv
// Converter-side model: offers raw readings and collects corrected results
`timescale 1ns/100ps
module adc_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Request from the bench
  input  wire logic        go,
  input  wire logic [2:0]  go_chan,
  input  wire logic [11:0] go_raw,
  // Raw reading side
  input  wire logic        adc_in_ready,
  output logic             adc_in_valid,
  output logic [2:0]       adc_in_chan,
  output logic [11:0]      adc_in_raw,
  // Corrected result side
  input  wire logic        adc_out_valid,
  input  wire logic [2:0]  adc_out_chan,
  input  wire logic [11:0] adc_out_data,
  output logic [11:0]      res_data,
  output logic [2:0]       res_chan,
  output logic [7:0]       res_cnt
);
  // Offer held until taken; released lines show the inverse so stale data cannot pass
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_in_valid <= 1'b0;
      adc_in_chan  <= 3'h0;
      adc_in_raw   <= 12'h000;
    end else if (go) begin
      adc_in_valid <= 1'b1;
      adc_in_chan  <= go_chan;
      adc_in_raw   <= go_raw;
    end else if (adc_in_valid && adc_in_ready) begin
      adc_in_valid <= 1'b0;
      adc_in_chan  <= ~adc_in_chan;
      adc_in_raw   <= ~adc_in_raw;
    end
  end
  // Result capture on the one-cycle pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_cnt  <= 8'h00;
      res_data <= 12'h000;
      res_chan <= 3'h0;
    end else if (adc_out_valid) begin
      res_cnt  <= res_cnt + 8'h01;
      res_data <= adc_out_data;
      res_chan <= adc_out_chan;
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the analog output and calibration block
`timescale 1ns/100ps
module testbench;
  import aocal_pkg::*;
  logic        sys_clk, rst_b, hsel, hwrite, go, hreadyout, hresp;
  logic        adc_in_ready, adc_in_valid, adc_out_valid;
  logic [31:0] haddr, hwdata, hrdata, rd, x;
  logic [1:0]  htrans, range_10v;
  logic [2:0]  hsize, go_chan, res_chan, adc_in_chan, adc_out_chan;
  logic [11:0] go_raw, res_data, adc_in_raw, adc_out_data, dac_code_0, dac_code_1, v;
  logic [7:0]  res_cnt;
  logic [23:0] cmd [6] = '{24'h190202, 24'h190102, 24'h180101, 24'h190203, 24'h190301, 24'h190101};
  logic [1:0]  rexp [6] = '{2'b10, 2'b11, 2'b11, 2'b11, 2'b11, 2'b10};
  int          errors, compares;

  analog_out_calibration #(.NCH(8)) i_analog_out_calibration (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_in_valid(adc_in_valid), .adc_in_chan(adc_in_chan), .adc_in_raw(adc_in_raw),
    .adc_in_ready(adc_in_ready), .adc_out_valid(adc_out_valid), .adc_out_chan(adc_out_chan),
    .adc_out_data(adc_out_data), .dac_code_0(dac_code_0), .dac_code_1(dac_code_1), .range_10v(range_10v));
  adc_model i_adc_model (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .go_chan(go_chan), .go_raw(go_raw),
    .adc_in_ready(adc_in_ready), .adc_in_valid(adc_in_valid), .adc_in_chan(adc_in_chan),
    .adc_in_raw(adc_in_raw), .adc_out_valid(adc_out_valid), .adc_out_chan(adc_out_chan),
    .adc_out_data(adc_out_data), .res_data(res_data), .res_chan(res_chan), .res_cnt(res_cnt));

  // Free-running 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Gain first, truncate toward zero, then offset and clamp
  function automatic logic [11:0] corr(input int a, input int k, input int o);
    int q;
    q = a * (10000 + k) / 10000 + o;
    corr = (q < 0) ? 12'h000 : (q > 4095) ? 12'hFFF : q[11:0];
  endfunction

  task automatic stop_test();
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for hready; the bus never answers late enough to need 50
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      stop_test();
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask
  // Poll status until the correction engine has nothing busy or pending
  task automatic settle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[5:2] !== 4'h0 && n < 60);
    if (n >= 60) begin
      errors++;
      stop_test();
    end
  endtask
  // Offer one raw reading and wait for its corrected result
  task automatic sample(input logic [2:0] c, input logic [11:0] r);
    logic [7:0] n0;
    int         n;
    n0 = res_cnt;
    go      <= 1'b1;
    go_chan <= c;
    go_raw  <= r;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    while (res_cnt === n0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      stop_test();
    end
  endtask

  // Main sequence
  initial begin
    {hsel, hwrite, go, rst_b} = 4'h0;
    {haddr, hwdata, htrans, go_chan, go_raw} = '0;
    hsize    = 3'h2;
    errors   = 0;
    compares = 0;
    x        = 32'h4973;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    check(range_10v, 2'b00);
    // Range commands, including refused number, range and channel codes
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF_SETTING, {8'h00, cmd[i]});
      bus(1'b0, OFF_STATUS, 32'h0);
      check(rd[1:0], rexp[i]);
      check(range_10v, rexp[i]);
    end
    bus(1'b1, OFF_OUT_VAL0, 32'd2048);
    settle();
    check(dac_code_0, 12'd2048);
    // Channel two: both corners then random set values; channel one must hold
    for (int i = 0; i < 5; i++) begin
      x = lfsr(x);
      v = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : x[11:0];
      bus(1'b1, OFF_OUT_VAL1, {20'h0, v});
      settle();
      check(dac_code_1, v);
      check(dac_code_0, 12'd2048);
      bus(1'b0, OFF_OUT_VAL1, 32'h0);
      check(rd, {20'h0, v});
    end
    sample(3'h3, 12'd2048);
    check(res_data, 12'd2048);
    check(res_chan, 3'h3);
    // Store constants; channel two offset stays at zero
    bus(1'b1, OFF_OUT_GN0, 32'hFFFFFFC4);
    bus(1'b1, OFF_OUT_OF0, 32'd150);
    bus(1'b0, OFF_OUT_OF0, 32'h0);
    check(rd, 32'd100);
    bus(1'b1, OFF_OUT_GN1, 32'd81);
    bus(1'b1, OFF_OUT_OF1, 32'h0);
    bus(1'b1, 8'h4C, 32'd146);
    bus(1'b1, 8'h6C, 32'hFFFFFFFB);
    bus(1'b1, 8'h74, 32'hFFFFFF9C);
    // Stored constants stay inactive until the self restart
    sample(3'h3, 12'd3230);
    check(res_data, 12'd3230);
    bus(1'b1, OFF_CAL_CTRL, 32'h1);
    settle();
    bus(1'b1, OFF_OUT_VAL0, 32'd2048);
    settle();
    check(dac_code_0, 12'd2048);
    bus(1'b1, OFF_CAL_CTRL, 32'h3);
    settle();
    check(range_10v, 2'b00);
    check(dac_code_0, corr(0, -60, 100));
    bus(1'b1, OFF_OUT_VAL0, 32'd2048);
    settle();
    check(dac_code_0, corr(2048, -60, 100));
    bus(1'b1, OFF_OUT_VAL1, 32'hFFF);
    settle();
    check(dac_code_1, corr(4095, 81, 0));
    bus(1'b0, OFF_OUT_CD1, 32'h0);
    check(rd, {20'h0, corr(4095, 81, 0)});
    sample(3'h3, 12'd3230);
    check(res_data, corr(3230, 146, -5));
    sample(3'h5, 12'd80);
    check(res_data, corr(80, 0, -100));
    bus(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0);
    stop_test();
  end
endmodule
